/* File: ext_bus_port.sv */
// The register addresses and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps

// What this block does
// - One data strobe pulse per external transfer
// - Write data valid by data strobe fall
// - Address strobe pulses at machine cycle start
// - Address held valid at address strobe rise
// - Software floats strobes, direction, high port and address-mode low port
// - Direction line low on writes, high reads
// - High port nibbles: general I/O or address
// - Two control lines give high port handshake
// - Handshake direction follows upper nibble direction
// - Address A11-A8 low nibble, A15-A8 both
// - Nibble becomes I/O only by mode write or reset
// - Reset leaves all high port lines input
// - Low port set as whole byte, muxed bus
// - General port lines individually input or output
// - Data space select low for data loads
module ext_bus_port
    import ext_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output strobe_type strobe_out,
    output logic strobe_oe_n,
    input wire logic [7:0] high_port_in,
    output logic [7:0] high_port_out,
    output logic [7:0] high_port_oe_n,
    input wire logic [7:0] low_port_in,
    output logic [7:0] low_port_out,
    output logic [7:0] low_port_oe_n,
    input wire logic [7:0] gp_port_in,
    output logic [7:0] gp_port_out,
    output logic [7:0] gp_port_oe_n,
    input wire logic high_port_handshake_valid_n_in,
    output logic high_port_handshake_valid_n_out,
    output logic high_port_handshake_valid_n_oe_n,
    input wire logic high_port_handshake_ready_in,
    output logic high_port_handshake_ready_out,
    output logic high_port_handshake_ready_oe_n
);
    function automatic logic [1:0] nibble_mode(input logic [3:0] modes,
                                               input int nib);
        nibble_mode = nib == 0 ? modes[1:0] : modes[3:2];
    endfunction : nibble_mode
    logic step_tick;
    // Software state
    logic float_bus;
    logic hs_enable;
    logic [3:0] p0_mode;
    logic [7:0] p0_data;
    logic [1:0] p1_mode;
    logic [7:0] p1_data;
    logic [7:0] p2_dir;
    logic [7:0] p2_data;
    logic [15:0] xaddr;
    logic [7:0] xdata;
    logic [7:0] xread;
    logic xwrite;
    logic xdata_space;
    logic go_pending;
    logic hs_pending;
    logic hs_full;
    logic [7:0] hs_latch;
    logic [31:0] prdata_q;
    logic next_float_bus;
    logic next_hs_enable;
    logic [3:0] next_p0_mode;
    logic [7:0] next_p0_data;
    logic [1:0] next_p1_mode;
    logic [7:0] next_p1_data;
    logic [7:0] next_p2_dir;
    logic [7:0] next_p2_data;
    logic [15:0] next_xaddr;
    logic [7:0] next_xdata;
    logic [7:0] next_xread;
    logic next_xwrite;
    logic next_xdata_space;
    logic next_go_pending;
    logic next_hs_pending;
    logic next_hs_full;
    logic [7:0] next_hs_latch;
    // Bus cycle state
    cycle_state_type state;
    cycle_state_type next_state;
    // Registered pins
    strobe_type next_strobe_out;
    logic next_strobe_oe_n;
    logic [7:0] next_high_port_out;
    logic [7:0] next_high_port_oe_n;
    logic [7:0] next_low_port_out;
    logic [7:0] next_low_port_oe_n;
    logic next_valid_n_out;
    logic next_valid_n_oe_n;
    logic next_ready_out;
    logic next_ready_oe_n;
    logic wr_access;
    logic rd_access;
    logic addr_hit;
    logic busy;
    logic hs_source;
    logic [31:0] rd_value;
    step_divider u_step_divider (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .step_tick(step_tick)
    );
    assign wr_access = psel && penable && pwrite;
    assign rd_access = psel && !penable && !pwrite;
    assign busy = state != st_idle || go_pending;
    // Handshake direction comes from the upper nibble alone
    assign hs_source = nibble_mode(p0_mode, 1) == mode_output;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    always_comb
    begin
        addr_hit = 1'b1;
        rd_value = 32'h0000_0000;
        case (paddr)
            addr_ctrl: rd_value = {30'h0, hs_enable, float_bus};
            addr_p0_mode: rd_value = {28'h0, p0_mode};
            addr_p0_data: rd_value = {24'h0,
                (hs_enable && !hs_source) ? hs_latch : high_port_in};
            addr_p1_mode: rd_value = {30'h0, p1_mode};
            addr_p1_data: rd_value = {24'h0, low_port_in};
            addr_p2_dir: rd_value = {24'h0, p2_dir};
            addr_p2_data: rd_value = {24'h0, gp_port_in};
            addr_xaddr: rd_value = {16'h0, xaddr};
            addr_xdata: rd_value = {24'h0, xread};
            addr_xcmd: rd_value = {31'h0, busy};
            default: addr_hit = 1'b0;
        endcase
    end
    assign pslverr = psel && penable && !addr_hit;
    always_comb
    begin
        next_float_bus = float_bus;
        next_hs_enable = hs_enable;
        next_p0_mode = p0_mode;
        next_p0_data = p0_data;
        next_p1_mode = p1_mode;
        next_p1_data = p1_data;
        next_p2_dir = p2_dir;
        next_p2_data = p2_data;
        next_xaddr = xaddr;
        next_xdata = xdata;
        next_xread = xread;
        next_xwrite = xwrite;
        next_xdata_space = xdata_space;
        next_go_pending = go_pending;
        next_hs_pending = hs_pending;
        next_hs_full = hs_full;
        next_hs_latch = hs_latch;
        next_state = state;
        // Handshake clears come first so a new event in the same cycle wins
        if (hs_pending && high_port_handshake_ready_in)
            next_hs_pending = 1'b0;
        if (rd_access && paddr == addr_p0_data
            && high_port_handshake_valid_n_in)
            next_hs_full = 1'b0;
        if (hs_enable && !hs_source && !hs_full
            && !high_port_handshake_valid_n_in)
        begin
            next_hs_full = 1'b1;
            next_hs_latch = high_port_in;
        end
        if (wr_access)
        begin
            case (paddr)
                addr_ctrl:
                begin
                    next_float_bus = pwdata[ctrl_float_bit];
                    next_hs_enable = pwdata[ctrl_hs_bit];
                end
                addr_p0_mode: next_p0_mode = pwdata[3:0];
                addr_p0_data:
                begin
                    next_p0_data = pwdata[7:0];
                    if (hs_enable && hs_source)
                        next_hs_pending = 1'b1;
                end
                addr_p1_mode: next_p1_mode = pwdata[1:0];
                addr_p1_data: next_p1_data = pwdata[7:0];
                addr_p2_dir: next_p2_dir = pwdata[7:0];
                addr_p2_data: next_p2_data = pwdata[7:0];
                addr_xaddr: next_xaddr = pwdata[15:0];
                addr_xdata: next_xdata = pwdata[7:0];
                addr_xcmd:
                begin
                    // A command given while busy is dropped
                    if (pwdata[cmd_go_bit] && !busy)
                    begin
                        next_go_pending = 1'b1;
                        next_xwrite = pwdata[cmd_write_bit];
                        next_xdata_space = pwdata[cmd_data_space_bit];
                    end
                end
                default: next_go_pending = go_pending;
            endcase
        end
        // One step per divider tick keeps every phase a whole machine step
        if (step_tick)
        begin
            case (state)
                st_idle:
                begin
                    if (go_pending && !float_bus)
                    begin
                        next_go_pending = 1'b0;
                        next_state = st_addr;
                    end
                end
                st_addr: next_state = st_hold;
                st_hold: next_state = st_data;
                st_data:
                begin
                    // Sampled on the clock before the data strobe rises
                    if (!xwrite)
                        next_xread = low_port_in;
                    next_state = st_done;
                end
                st_done: next_state = st_idle;
                default: next_state = st_idle;
            endcase
        end
    end
    always_comb
    begin
        next_strobe_out.address_strobe_n = state != st_addr;
        next_strobe_out.data_strobe_n = state != st_data;
        next_strobe_out.read_write_n =
            !(xwrite && state != st_idle);
        next_strobe_out.data_space_select_n =
            !(xdata_space && state != st_idle);
        next_strobe_oe_n = float_bus;
        // Address nibbles hold through the whole cycle, so they are
        // valid when the address strobe rises
        next_high_port_out = p0_data;
        for (int n = 0; n < 2; n++)
        begin
            if (nibble_mode(p0_mode, n) == mode_address)
                next_high_port_out[n * 4 +: 4] =
                    xaddr[8 + n * 4 +: 4];
            next_high_port_oe_n[n * 4 +: 4] = {4{float_bus
                || nibble_mode(p0_mode, n) == mode_input}};
        end
        next_low_port_out = p1_data;
        next_low_port_oe_n = {8{p1_mode != mode_output}};
        if (p1_mode == mode_address)
        begin
            next_low_port_oe_n = 8'hff;
            if (state == st_addr)
            begin
                next_low_port_out = xaddr[7:0];
                next_low_port_oe_n = 8'h00;
            end
            else if ((state == st_hold || state == st_data) && xwrite)
            begin
                // Driven a step ahead of the strobe fall
                next_low_port_out = xdata;
                next_low_port_oe_n = 8'h00;
            end
            if (float_bus)
                next_low_port_oe_n = 8'hff;
        end
        next_valid_n_out = !hs_pending;
        next_valid_n_oe_n = !(hs_enable && hs_source);
        next_ready_out = !hs_full;
        next_ready_oe_n = !(hs_enable && !hs_source);
    end
    // General port: each line drives when its direction bit is set
    generate
        for (genvar g = 0; g < 8; g++)
        begin : gen_gp
            always_ff @(posedge sys_clk or negedge resetn)
            begin
                if (!resetn)
                begin
                    gp_port_out[g] <= 1'b0;
                    gp_port_oe_n[g] <= 1'b1;
                end
                else
                begin
                    gp_port_out[g] <= p2_data[g];
                    gp_port_oe_n[g] <= !p2_dir[g];
                end
            end
        end
    endgenerate
    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            float_bus <= 1'b0;
            hs_enable <= 1'b0;
            p0_mode <= p0_mode_reset;
            p0_data <= 8'h00;
            p1_mode <= p1_mode_reset;
            p1_data <= 8'h00;
            p2_dir <= p2_dir_reset;
            p2_data <= 8'h00;
            xaddr <= 16'h0000;
            xdata <= 8'h00;
            xread <= 8'h00;
            xwrite <= 1'b0;
            xdata_space <= 1'b0;
            go_pending <= 1'b0;
            hs_pending <= 1'b0;
            hs_full <= 1'b0;
            hs_latch <= 8'h00;
            prdata_q <= 32'h0000_0000;
            state <= st_idle;
            strobe_out <= '1;
            strobe_oe_n <= 1'b0;
            high_port_out <= 8'h00;
            high_port_oe_n <= 8'hff;
            low_port_out <= 8'h00;
            low_port_oe_n <= 8'hff;
            high_port_handshake_valid_n_out <= 1'b1;
            high_port_handshake_valid_n_oe_n <= 1'b1;
            high_port_handshake_ready_out <= 1'b1;
            high_port_handshake_ready_oe_n <= 1'b1;
        end
        else
        begin
            float_bus <= next_float_bus;
            hs_enable <= next_hs_enable;
            p0_mode <= next_p0_mode;
            p0_data <= next_p0_data;
            p1_mode <= next_p1_mode;
            p1_data <= next_p1_data;
            p2_dir <= next_p2_dir;
            p2_data <= next_p2_data;
            xaddr <= next_xaddr;
            xdata <= next_xdata;
            xread <= next_xread;
            xwrite <= next_xwrite;
            xdata_space <= next_xdata_space;
            go_pending <= next_go_pending;
            hs_pending <= next_hs_pending;
            hs_full <= next_hs_full;
            hs_latch <= next_hs_latch;
            if (rd_access)
                prdata_q <= rd_value;
            state <= next_state;
            strobe_out <= next_strobe_out;
            strobe_oe_n <= next_strobe_oe_n;
            high_port_out <= next_high_port_out;
            high_port_oe_n <= next_high_port_oe_n;
            low_port_out <= next_low_port_out;
            low_port_oe_n <= next_low_port_oe_n;
            high_port_handshake_valid_n_out <= next_valid_n_out;
            high_port_handshake_valid_n_oe_n <= next_valid_n_oe_n;
            high_port_handshake_ready_out <= next_ready_out;
            high_port_handshake_ready_oe_n <= next_ready_oe_n;
        end
    end
endmodule : ext_bus_port

/* File: ext_bus_pkg.sv */
package ext_bus_pkg;

    // APB byte addresses
    localparam logic [7:0] addr_ctrl = 8'h00;
    localparam logic [7:0] addr_p0_mode = 8'h04;
    localparam logic [7:0] addr_p0_data = 8'h08;
    localparam logic [7:0] addr_p1_mode = 8'h0c;
    localparam logic [7:0] addr_p1_data = 8'h10;
    localparam logic [7:0] addr_p2_dir = 8'h14;
    localparam logic [7:0] addr_p2_data = 8'h18;
    localparam logic [7:0] addr_xaddr = 8'h1c;
    localparam logic [7:0] addr_xdata = 8'h20;
    localparam logic [7:0] addr_xcmd = 8'h24;

    // Control register bits
    localparam int ctrl_float_bit = 0;
    localparam int ctrl_hs_bit = 1;

    // Command register bits
    localparam int cmd_go_bit = 0;
    localparam int cmd_write_bit = 1;
    localparam int cmd_data_space_bit = 2;
    localparam int stat_busy_bit = 0;

    // Port 0 nibble modes and port 1 byte modes, two bits each
    localparam logic [1:0] mode_input = 2'h0;
    localparam logic [1:0] mode_output = 2'h1;
    localparam logic [1:0] mode_address = 2'h2;

    localparam logic [3:0] p0_mode_reset = 4'h0;
    localparam logic [1:0] p1_mode_reset = 2'h0;
    localparam logic [7:0] p2_dir_reset = 8'h00;

    // Machine step time: 125 ns asked, counted in whole sys_clk cycles of 4 ns, which gives 31 cycles or 124 ns
    localparam int clk_period_ps = 4000;
    localparam int step_time_ns = 125;
    localparam int step_cycles = (step_time_ns * 1000) / clk_period_ps;

    typedef enum logic [2:0] {
        st_idle,
        st_addr,
        st_hold,
        st_data,
        st_done
    } cycle_state_type;

    typedef struct packed {
        logic address_strobe_n;
        logic data_strobe_n;
        logic read_write_n;
        logic data_space_select_n;
    } strobe_type;

endpackage : ext_bus_pkg

/* File: step_divider.sv */
`timescale 1ns/1ps

module step_divider
    import ext_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    output logic step_tick
);

    localparam logic [7:0] last_count = 8'(step_cycles - 1);

    logic [7:0] count;
    logic [7:0] next_count;
    logic next_step_tick;

    always_comb
    begin
        next_step_tick = 1'b0;
        next_count = count + 8'h01;
        if (count == last_count)
        begin
            next_count = 8'h00;
            next_step_tick = 1'b1;
        end
    end

    always_ff @(posedge sys_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            count <= 8'h00;
            step_tick <= 1'b0;
        end
        else
        begin
            count <= next_count;
            step_tick <= next_step_tick;
        end
    end

endmodule : step_divider

/* File: ext_bus_port_chk_sva.sv */
`timescale 1ns/1ps

module ext_bus_port_chk
    import ext_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire logic resetn,
    input wire strobe_type strobe_out,
    input wire logic strobe_oe_n,
    input wire logic [7:0] low_port_out,
    input wire logic [7:0] low_port_oe_n,
    input wire logic [7:0] high_port_oe_n,
    input wire logic high_port_handshake_valid_n_oe_n
);
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    logic as_n;
    logic ds_n;
    assign as_n = strobe_out.address_strobe_n;
    assign ds_n = strobe_out.data_strobe_n;

    // One machine step is 31 clocks; one clock of slack either way
    sequence as_back_up;
        ##[30:32] $rose(as_n);
    endsequence
    sequence ds_back_up;
        ##[30:32] $rose(ds_n);
    endsequence
    sequence ds_down;
        ##[30:32] $fell(ds_n);
    endsequence

    AST_AS_ONE_STEP: assert property ($fell(as_n) |-> as_back_up)
        else $error("address strobe low for wrong time");
    AST_DS_ONE_STEP: assert property ($fell(ds_n) |-> ds_back_up)
        else $error("data strobe low for wrong time");
    AST_DS_AFTER_AS: assert property ($rose(as_n) |-> ds_down)
        else $error("data strobe missing after address phase");
    AST_DS_NEEDS_AS: assert property ($fell(ds_n) |-> !$past(as_n, 40))
        else $error("data strobe without its address strobe");
    AST_ADDR_HELD: assert property ($fell(as_n) |=>
        (low_port_oe_n == 8'h00 && $stable(low_port_out))[*8])
        else $error("address not held on low port");
    AST_WDATA_VALID: assert property ($fell(ds_n) &&
        !strobe_out.read_write_n |->
        low_port_oe_n == 8'h00 && $stable(low_port_out))
        else $error("write data not valid at data strobe");
    AST_READ_RELEASE: assert property (!ds_n &&
        strobe_out.read_write_n |-> low_port_oe_n == 8'hff)
        else $error("low port driven during read");
    AST_RW_DIR: assert property (!ds_n |->
        strobe_out.read_write_n == low_port_oe_n[0])
        else $error("direction line disagrees with bus drive");
    AST_FLOAT: assert property (strobe_oe_n && $past(strobe_oe_n) |->
        low_port_oe_n == 8'hff)
        else $error("low port driven while floated");
    AST_RESET_IN: assert property ($rose(resetn) |->
        high_port_oe_n == 8'hff && high_port_handshake_valid_n_oe_n)
        else $error("high port not input after reset");
endmodule : ext_bus_port_chk

bind ext_bus_port ext_bus_port_chk chk_u (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .strobe_out(strobe_out),
    .strobe_oe_n(strobe_oe_n),
    .low_port_out(low_port_out),
    .low_port_oe_n(low_port_oe_n),
    .high_port_oe_n(high_port_oe_n),
    .high_port_handshake_valid_n_oe_n(high_port_handshake_valid_n_oe_n)
);

/* File: ext_mem_model.sv */
`timescale 1ns/1ps

module ext_mem_model
    import ext_bus_pkg::*;
(
    input wire logic sys_clk,
    input wire strobe_type strobe,
    input wire logic [7:0] bus_out,
    input wire logic [7:0] bus_oe_n,
    output logic [7:0] bus_in
);
    logic [7:0] addr_latch = 8'h00;
    logic [7:0] last = 8'h00;
    logic reading;

    assign reading = !strobe.data_strobe_n && strobe.read_write_n;

    always @(posedge sys_clk)
    begin
        if (!strobe.address_strobe_n)
            addr_latch <= bus_out;
        last <= bus_in;
    end

    // Released bus toggles so a stale value can never pass as read data
    always_comb
    begin
        if (bus_oe_n == 8'h00)
            bus_in = bus_out;
        else if (reading)
            bus_in = addr_latch ^ 8'h3c;
        else
            bus_in = ~last;
    end
endmodule : ext_mem_model

/* File: ext_bus_port_tb.sv */
`timescale 1ns/1ps

module ext_bus_port_tb
    import ext_bus_pkg::*;
;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rdata;
    logic pready, pslverr, serr, strobe_oe_n;
    strobe_type strobe_out;
    logic [7:0] hp_in, hp_out, hp_oe_n, lp_in, lp_out, lp_oe_n;
    logic [7:0] gp_in, gp_out, gp_oe_n, hp_ext = 8'h00, gp_ext = 8'h00;
    logic hv_in, hv_out, hv_oe_n, hr_in, hr_out, hr_oe_n;
    logic hv_ext = 1'b1, hr_ext = 1'b0, as_q = 1'b1, ds_q = 1'b1;
    logic [7:0] a_lo, a_hi, w_data;
    logic w_rw, w_dm;
    int mismatches = 0, n_compared = 0, n_as = 0, n_ds = 0;

    always #2 sys_clk = ~sys_clk;

    assign hp_in = (hp_out & ~hp_oe_n) | (hp_ext & hp_oe_n);
    assign gp_in = (gp_out & ~gp_oe_n) | (gp_ext & gp_oe_n);
    assign hv_in = hv_oe_n ? hv_ext : hv_out;
    assign hr_in = hr_oe_n ? hr_ext : hr_out;

    ext_bus_port dut_u (.sys_clk(sys_clk), .resetn(resetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strobe_out(strobe_out), .strobe_oe_n(strobe_oe_n),
        .high_port_in(hp_in), .high_port_out(hp_out),
        .high_port_oe_n(hp_oe_n), .low_port_in(lp_in),
        .low_port_out(lp_out), .low_port_oe_n(lp_oe_n),
        .gp_port_in(gp_in), .gp_port_out(gp_out), .gp_port_oe_n(gp_oe_n),
        .high_port_handshake_valid_n_in(hv_in),
        .high_port_handshake_valid_n_out(hv_out),
        .high_port_handshake_valid_n_oe_n(hv_oe_n),
        .high_port_handshake_ready_in(hr_in),
        .high_port_handshake_ready_out(hr_out),
        .high_port_handshake_ready_oe_n(hr_oe_n));

    ext_mem_model mem_u (.sys_clk(sys_clk), .strobe(strobe_out),
        .bus_out(lp_out), .bus_oe_n(lp_oe_n), .bus_in(lp_in));

    // Sample pins away from the launching edge
    always @(negedge sys_clk)
    begin
        if (as_q && !strobe_out.address_strobe_n)
        begin
            n_as++;
            a_lo = lp_out;
            a_hi = hp_out;
        end
        if (ds_q && !strobe_out.data_strobe_n)
        begin
            n_ds++;
            w_data = lp_out;
            w_rw = strobe_out.read_write_n;
            w_dm = strobe_out.data_space_select_n;
        end
        as_q = strobe_out.address_strobe_n;
        ds_q = strobe_out.data_strobe_n;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
        end
    endtask : check

    task automatic stop_test;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do
            @(posedge sys_clk);
        while (pready !== 1'b1);
        rdata = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_idle;
        for (int i = 0; i < 200; i++)
        begin
            apb(1'b0, addr_xcmd, 32'h0);
            if (rdata[stat_busy_bit] === 1'b0)
                break;
        end
    endtask : wait_idle

    task automatic xfer(input logic wr, input logic dsp,
        input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, addr_xaddr, {16'h0000, a});
        apb(1'b1, addr_xdata, {24'h000000, d});
        n_as = 0;
        n_ds = 0;
        apb(1'b1, addr_xcmd, {29'h0, dsp, wr, 1'b1});
        wait_idle();
    endtask : xfer

    task automatic settle;
        repeat (3) @(negedge sys_clk);
    endtask : settle

    initial
    begin
        #200000;
        mismatches++;
        $display("CHECK FAILED at %0t: watchdog expired", $time);
        stop_test();
    end

    initial
    begin
        repeat (10) @(posedge sys_clk);
        resetn <= 1'b1;
        settle();
        check(hp_oe_n, 8'hff);
        check({6'h00, hv_oe_n, hr_oe_n}, 8'h03);
        apb(1'b0, addr_p0_mode, 32'h0);
        check(rdata[7:0], 8'h00);
        apb(1'b0, 8'h40, 32'h0);
        check({7'h00, serr}, 8'h01);
        check(rdata[7:0], 8'h00);
        $display("test reset done");

        apb(1'b1, addr_p1_mode, 32'h2);
        apb(1'b1, addr_p0_mode, 32'ha);
        xfer(1'b1, 1'b1, 16'habcd, 8'h5a);
        check(8'(n_as), 8'h01);
        check(8'(n_ds), 8'h01);
        check(a_lo, 8'hcd);
        check(a_hi, 8'hab);
        check(w_data, 8'h5a);
        check({6'h00, w_rw, w_dm}, 8'h00);
        $display("test external write done");

        apb(1'b1, addr_p0_mode, 32'h6);
        apb(1'b1, addr_p0_data, 32'h50);
        xfer(1'b0, 1'b0, 16'h0321, 8'h00);
        check(a_hi, 8'h53);
        check({6'h00, w_rw, w_dm}, 8'h03);
        check(8'(n_ds), 8'h01);
        apb(1'b0, addr_xdata, 32'h0);
        check(rdata[7:0], 8'h1d);
        $display("test external read done");

        apb(1'b1, addr_ctrl, 32'h1);
        settle();
        check({7'h00, strobe_oe_n}, 8'h01);
        check(lp_oe_n, 8'hff);
        n_ds = 0;
        apb(1'b1, addr_xcmd, 32'h1);
        repeat (200) @(posedge sys_clk);
        check(8'(n_ds), 8'h00);
        apb(1'b1, addr_ctrl, 32'h0);
        wait_idle();
        check(8'(n_ds), 8'h01);
        $display("test float done");

        gp_ext <= 8'hc3;
        apb(1'b1, addr_p2_dir, 32'ha5);
        apb(1'b1, addr_p2_data, 32'h3c);
        settle();
        check(gp_oe_n, 8'h5a);
        check(gp_out & 8'ha5, 8'h24);
        apb(1'b0, addr_p2_data, 32'h0);
        check(rdata[7:0], 8'h66);
        apb(1'b1, addr_p1_mode, 32'h1);
        apb(1'b1, addr_p1_data, 32'h69);
        settle();
        check(lp_oe_n, 8'h00);
        check(lp_out, 8'h69);
        apb(1'b0, addr_p1_data, 32'h0);
        check(rdata[7:0], 8'h69);
        $display("test general port done");

        apb(1'b1, addr_ctrl, 32'h2);
        apb(1'b1, addr_p0_mode, 32'h0);
        settle();
        check({6'h00, hv_oe_n, hr_oe_n}, 8'h02);
        check({7'h00, hr_out}, 8'h01);
        @(posedge sys_clk);
        hp_ext <= 8'h77;
        hv_ext <= 1'b0;
        settle();
        check({7'h00, hr_out}, 8'h00);
        @(posedge sys_clk);
        hv_ext <= 1'b1;
        apb(1'b0, addr_p0_data, 32'h0);
        check(rdata[7:0], 8'h77);
        settle();
        check({7'h00, hr_out}, 8'h01);
        apb(1'b1, addr_p0_mode, 32'h5);
        apb(1'b1, addr_p0_data, 32'h96);
        settle();
        check({6'h00, hv_oe_n, hr_oe_n}, 8'h01);
        check(hp_out, 8'h96);
        check({7'h00, hv_out}, 8'h00);
        @(posedge sys_clk);
        hr_ext <= 1'b1;
        settle();
        check({7'h00, hv_out}, 8'h01);
        $display("test handshake done");
        stop_test();
    end
endmodule : ext_bus_port_tb
